/* rtl/dac_ctrl_pkg.sv */
package dac_ctrl_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CODE_W = 16;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned PHASE_W = 24;

   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_GAIN = 4'h1;
   localparam logic [3:0] ADDR_SWITCH = 4'h2;
   localparam logic [3:0] ADDR_PULSE_LOW = 4'h3;
   localparam logic [3:0] ADDR_PULSE_HIGH = 4'h4;
   localparam logic [3:0] ADDR_DC_LEVEL = 4'h5;
   localparam logic [3:0] ADDR_SINE_FREQ = 4'h6;
   localparam logic [3:0] ADDR_SINE_AMP = 4'h7;
   localparam logic [3:0] ADDR_STATUS = 4'h8;

   localparam int unsigned STAT_READY_BIT = 0;
   localparam int unsigned STAT_UNSETTLED_BIT = 1;
   localparam int unsigned STAT_SYNC_BIT = 2;
   localparam int unsigned STAT_MODE_LSB = 4;

   typedef enum logic [1:0] {
      MODE_SINE = 2'b00,
      MODE_DC = 2'b01,
      MODE_PULSE = 2'b11,
      MODE_DATA = 2'b10
   } mode_t;

   typedef enum logic [1:0] {
      ST_POR = 2'b00,
      ST_PDOWN = 2'b01,
      ST_HOLD = 2'b11,
      ST_RUN = 2'b10
   } rst_state_t;

   localparam int unsigned POR_CYCLES_DEF = 65536;
   localparam logic [1:0] RESET_HOLD = 2'h2;
   localparam logic [3:0] SAMPLE_LAST = 4'hf;
   localparam logic [3:0] SYNC_FIRST_LOAD = 4'h7;
   localparam int unsigned UPDATE_DELAY = 4;
   localparam logic [8:0] SETTLE_CYCLES = 9'h190;
   localparam logic [4:0] DENSITY_MID = 5'h08;
   localparam logic [4:0] DENSITY_LOW = 5'h04;
   localparam logic [4:0] DENSITY_HIGH = 5'h0c;
   localparam logic signed [15:0] FS_STEP = 16'sh1fff;
   localparam logic [2:0] GAIN_MAX_SHIFT = 3'h6;
   localparam logic [15:0] HIST_MID = 16'h5555;

   localparam mode_t MODE_RST = MODE_SINE;
   localparam logic [2:0] GAIN_RST = 3'h0;
   localparam logic [2:0] SWITCH_RST = 3'h0;
   localparam logic [15:0] PULSE_RST = 16'h0000;
   localparam logic [15:0] DC_RST = 16'h0000;
   localparam logic [15:0] SINE_FREQ_RST = 16'h01a3;
   localparam logic [7:0] SINE_AMP_RST = 8'h01;
endpackage

/* rtl/sync_edge.sv */
`timescale 1ns/100ps
module sync_edge
   import dac_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic din,
   input wire logic init,
   output logic level,
   output logic rise
);
   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic prev_q, prev_d;

   always_comb begin
      meta_d = meta_q;
      sync_d = sync_q;
      prev_d = prev_q;
      if (ce) begin
         meta_d = din;
         sync_d = meta_q;
         prev_d = init ? meta_q : sync_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // Rise only from the second stage against its previous value; while init is high prev loads the first stage, so no rise
   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
endmodule

/* rtl/dac_ctrl.sv */
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module dac_ctrl
   import dac_ctrl_pkg::*;
#(
   parameter int unsigned POR_CYCLES = POR_CYCLES_DEF
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic switch_or_bitstream_in,
   input wire logic sync_in,
   input wire logic reset_powerdown_pin,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rd_data,
   output logic signed [CODE_W-1:0] dac_code,
   output logic output_oe_n,
   output logic [2:0] switch_ctrl,
   output logic ready,
   output logic unsettled
);
   function automatic logic [4:0] ones_count(input logic [15:0] v);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < 16; i++) begin
         n = n + {4'h0, v[i]};
      end
      return n;
   endfunction

   function automatic logic signed [15:0] apply_gain(input logic signed [15:0] c, input logic [2:0] g);
      logic [2:0] s;
      s = (g > GAIN_MAX_SHIFT) ? GAIN_MAX_SHIFT : g;
      return c >>> s;
   endfunction

   function automatic logic signed [15:0] density_code(input logic [15:0] h, input logic [2:0] g);
      logic [4:0] n;
      logic signed [5:0] d;
      logic signed [21:0] p;
      n = ones_count(h);
      if (n < DENSITY_LOW) begin
         n = DENSITY_LOW;
      end
      if (n > DENSITY_HIGH) begin
         n = DENSITY_HIGH;
      end
      d = $signed({1'b0, n}) - $signed({1'b0, DENSITY_MID});
      p = d * FS_STEP;
      return apply_gain(p[15:0], g);
   endfunction

   function automatic logic signed [15:0] sine_code(input logic [PHASE_W-1:0] ph, input logic [7:0] amp,
                                                    input logic [2:0] g);
      logic [14:0] p;
      logic [29:0] prod;
      logic [15:0] mag;
      logic [23:0] sc;
      logic signed [15:0] s;
      p = ph[PHASE_W-2 -: 15];
      prod = p * (15'h7fff - p);
      mag = {prod[28:14], 1'b0};
      sc = mag * amp;
      s = $signed({1'b0, sc[22:8]});
      if (ph[PHASE_W-1]) begin
         s = -s;
      end
      return apply_gain(s, g);
   endfunction

   // Reset release
   logic rst_m_q, rst_n_q;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   logic pin_level, sync_level, sync_rise;
   logic logic_rst;

   sync_edge u_pin_sync (
      .clk(clk_sys),
      .rst_n(rst_n_q),
      .ce(ce),
      .din(reset_powerdown_pin),
      .init(1'b0),
      .level(pin_level),
      .rise()
   );

   sync_edge u_sync_in (
      .clk(clk_sys),
      .rst_n(rst_n_q),
      .ce(ce),
      .din(sync_in),
      .init(logic_rst),
      .level(sync_level),
      .rise(sync_rise)
   );

   // Reset and power-down sequencing
   rst_state_t st_q, st_d;
   logic [16:0] por_q, por_d;
   logic [1:0] hold_q, hold_d;

   always_comb begin
      st_d = st_q;
      por_d = por_q;
      hold_d = hold_q;
      if (ce) begin
         unique case (st_q)
            ST_POR: begin
               if (por_q == 17'(POR_CYCLES - 1)) begin
                  st_d = ST_RUN;
               end else begin
                  por_d = por_q + 17'h00001;
               end
            end
            ST_PDOWN: begin
               if (pin_level) begin
                  st_d = ST_HOLD;
                  hold_d = 2'h0;
               end
            end
            ST_HOLD: begin
               if (hold_q == RESET_HOLD - 2'h1) begin
                  st_d = ST_RUN;
               end else begin
                  hold_d = hold_q + 2'h1;
               end
            end
            ST_RUN: begin
            end
         endcase
         if (!pin_level && st_q != ST_POR) begin
            st_d = ST_PDOWN;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= ST_POR;
         por_q <= 17'h00000;
         hold_q <= 2'h0;
      end else begin
         st_q <= st_d;
         por_q <= por_d;
         hold_q <= hold_d;
      end
   end

   assign logic_rst = (st_q != ST_RUN);

   // Register file
   mode_t mode_q, mode_d;
   logic [2:0] gain_q, gain_d;
   logic [2:0] sw_sel_q, sw_sel_d;
   logic [15:0] pulse_lo_q, pulse_lo_d;
   logic [15:0] pulse_hi_q, pulse_hi_d;
   logic [15:0] dc_q, dc_d;
   logic [15:0] freq_q, freq_d;
   logic [7:0] amp_q, amp_d;
   logic [DATA_W-1:0] rdat_q, rdat_d;
   logic settling;
   logic [DATA_W-1:0] status_word;

   assign status_word = DATA_W'({mode_q, 1'b0, sync_level, settling, ~logic_rst}) ;

   always_comb begin
      mode_d = mode_q;
      gain_d = gain_q;
      sw_sel_d = sw_sel_q;
      pulse_lo_d = pulse_lo_q;
      pulse_hi_d = pulse_hi_q;
      dc_d = dc_q;
      freq_d = freq_q;
      amp_d = amp_q;
      rdat_d = rdat_q;
      if (ce) begin
         rdat_d = '0;
         if (rd_en) begin
            unique case (addr)
               ADDR_MODE: rdat_d = DATA_W'(mode_q);
               ADDR_GAIN: rdat_d = DATA_W'(gain_q);
               ADDR_SWITCH: rdat_d = DATA_W'(sw_sel_q);
               ADDR_PULSE_LOW: rdat_d = pulse_lo_q;
               ADDR_PULSE_HIGH: rdat_d = pulse_hi_q;
               ADDR_DC_LEVEL: rdat_d = dc_q;
               ADDR_SINE_FREQ: rdat_d = freq_q;
               ADDR_SINE_AMP: rdat_d = DATA_W'(amp_q);
               ADDR_STATUS: rdat_d = status_word;
               default: rdat_d = '0;
            endcase
         end
         if (logic_rst) begin
            mode_d = MODE_RST;
            gain_d = GAIN_RST;
            sw_sel_d = SWITCH_RST;
            pulse_lo_d = PULSE_RST;
            pulse_hi_d = PULSE_RST;
            dc_d = DC_RST;
            freq_d = SINE_FREQ_RST;
            amp_d = SINE_AMP_RST;
         end else if (wr_en) begin
            unique case (addr)
               ADDR_MODE: mode_d = mode_t'(wr_data[1:0]);
               ADDR_GAIN: gain_d = wr_data[2:0];
               ADDR_SWITCH: sw_sel_d = wr_data[2:0];
               ADDR_PULSE_LOW: pulse_lo_d = wr_data;
               ADDR_PULSE_HIGH: pulse_hi_d = wr_data;
               ADDR_DC_LEVEL: dc_d = wr_data;
               ADDR_SINE_FREQ: freq_d = wr_data;
               ADDR_SINE_AMP: amp_d = wr_data[7:0];
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mode_q <= MODE_RST;
         gain_q <= GAIN_RST;
         sw_sel_q <= SWITCH_RST;
         pulse_lo_q <= PULSE_RST;
         pulse_hi_q <= PULSE_RST;
         dc_q <= DC_RST;
         freq_q <= SINE_FREQ_RST;
         amp_q <= SINE_AMP_RST;
         rdat_q <= '0;
      end else begin
         mode_q <= mode_d;
         gain_q <= gain_d;
         sw_sel_q <= sw_sel_d;
         pulse_lo_q <= pulse_lo_d;
         pulse_hi_q <= pulse_hi_d;
         dc_q <= dc_d;
         freq_q <= freq_d;
         amp_q <= amp_d;
         rdat_q <= rdat_d;
      end
   end

   // Signal path
   logic [3:0] tick_q, tick_d;
   logic [15:0] hist_q, hist_d;
   logic [UPDATE_DELAY-1:0] pipe_q, pipe_d;
   logic signed [15:0] pend_q, pend_d;
   logic [8:0] settle_q, settle_d;
   logic [PHASE_W-1:0] phase_q, phase_d;
   logic signed [15:0] code_q, code_d;
   logic oe_n_q, oe_n_d;
   logic [2:0] sw_q, sw_d;
   logic sample;

   assign sample = (tick_q == 4'h0);
   assign settling = (settle_q != 9'h000);

   always_comb begin
      tick_d = tick_q;
      hist_d = hist_q;
      pipe_d = pipe_q;
      pend_d = pend_q;
      settle_d = settle_q;
      phase_d = phase_q;
      code_d = code_q;
      oe_n_d = oe_n_q;
      sw_d = sw_q;
      if (ce) begin
         tick_d = sample ? SAMPLE_LAST : tick_q - 4'h1;
         pipe_d = {pipe_q[UPDATE_DELAY-2:0], 1'b0};
         if (settling) begin
            settle_d = settle_q - 9'h001;
         end
         if (sample && mode_q == MODE_SINE) begin
            phase_d = phase_q + PHASE_W'(freq_q);
         end
         unique case (mode_q)
            MODE_DATA: begin
               if (sample) begin
                  hist_d = {hist_q[14:0], switch_or_bitstream_in};
                  pend_d = density_code(hist_d, gain_q);
                  pipe_d[0] = 1'b1;
               end
               if (pipe_q[UPDATE_DELAY-1]) begin
                  code_d = pend_q;
               end
               if (sync_rise) begin
                  tick_d = SYNC_FIRST_LOAD;
                  hist_d = HIST_MID;
                  pipe_d = '0;
                  code_d = 16'sh0000;
                  settle_d = SETTLE_CYCLES;
               end
               sw_d = sw_sel_q;
            end
            MODE_SINE: begin
               if (sync_rise) begin
                  phase_d = '0;
                  code_d = 16'sh0000;
               end else begin
                  code_d = sine_code(phase_q, amp_q, gain_q);
               end
               sw_d = switch_or_bitstream_in ? sw_sel_q : 3'h0;
            end
            MODE_DC: begin
               code_d = apply_gain($signed(dc_q), gain_q);
               sw_d = switch_or_bitstream_in ? sw_sel_q : 3'h0;
            end
            MODE_PULSE: begin
               code_d = sync_level ? $signed(pulse_hi_q) : $signed(pulse_lo_q);
               sw_d = switch_or_bitstream_in ? sw_sel_q : 3'h0;
            end
         endcase
         oe_n_d = 1'b0;
         if (st_q == ST_PDOWN || (!pin_level && st_q != ST_POR)) begin
            oe_n_d = 1'b1;
            sw_d = 3'h0;
         end
         if (logic_rst) begin
            tick_d = SAMPLE_LAST;
            hist_d = HIST_MID;
            pipe_d = '0;
            pend_d = 16'sh0000;
            settle_d = 9'h000;
            phase_d = '0;
            code_d = 16'sh0000;
            if (st_q != ST_PDOWN && pin_level) begin
               sw_d = SWITCH_RST;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tick_q <= SAMPLE_LAST;
         hist_q <= HIST_MID;
         pipe_q <= '0;
         pend_q <= 16'sh0000;
         settle_q <= 9'h000;
         phase_q <= '0;
         code_q <= 16'sh0000;
         oe_n_q <= 1'b0;
         sw_q <= SWITCH_RST;
      end else begin
         tick_q <= tick_d;
         hist_q <= hist_d;
         pipe_q <= pipe_d;
         pend_q <= pend_d;
         settle_q <= settle_d;
         phase_q <= phase_d;
         code_q <= code_d;
         oe_n_q <= oe_n_d;
         sw_q <= sw_d;
      end
   end

   // Status outputs registered
   logic ready_q, ready_d;
   logic unset_q, unset_d;

   always_comb begin
      ready_d = ready_q;
      unset_d = unset_q;
      if (ce) begin
         ready_d = (st_d == ST_RUN);
         unset_d = (settle_d != 9'h000);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ready_q <= 1'b0;
         unset_q <= 1'b0;
      end else begin
         ready_q <= ready_d;
         unset_q <= unset_d;
      end
   end

   assign rd_data = rdat_q;
   assign dac_code = code_q;
   assign output_oe_n = oe_n_q;
   assign switch_ctrl = sw_q;
   assign ready = ready_q;
   assign unsettled = unset_q;
endmodule

/* bench/dac_ctrl_monitor.sv */
`timescale 1ns/100ps
module dac_ctrl_monitor
   import dac_ctrl_pkg::*;
#(
   parameter int unsigned POR_CYCLES = POR_CYCLES_DEF
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic switch_or_bitstream_in,
   input wire logic sync_in,
   input wire logic reset_powerdown_pin,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic signed [CODE_W-1:0] dac_code,
   input wire logic output_oe_n,
   input wire logic [2:0] switch_ctrl,
   input wire logic ready,
   input wire logic unsettled
);
   mode_t mode_q;
   logic [2:0] sw_q;
   logic [15:0] lo_q, hi_q;
   logic [9:0] on_q;
   logic [17:0] up_q;
   logic seen_q;
   // Shadow of the mode, switch and pulse-level fields
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mode_q <= MODE_RST;
         sw_q <= SWITCH_RST;
         lo_q <= PULSE_RST;
         hi_q <= PULSE_RST;
         on_q <= 10'h000;
         up_q <= 18'h00000;
         seen_q <= 1'b0;
      end else begin
         on_q <= unsettled ? on_q + 10'h001 : 10'h000;
         if (!seen_q) up_q <= up_q + 18'h00001;
         if (ready) seen_q <= 1'b1;
         if (!ready) begin
            mode_q <= MODE_RST;
            sw_q <= SWITCH_RST;
            lo_q <= PULSE_RST;
            hi_q <= PULSE_RST;
         end else if (wr_en && ce) begin
            case (addr)
               ADDR_MODE: mode_q <= mode_t'(wr_data[1:0]);
               ADDR_SWITCH: sw_q <= wr_data[2:0];
               ADDR_PULSE_LOW: lo_q <= wr_data;
               ADDR_PULSE_HIGH: hi_q <= wr_data;
               default: ;
            endcase
         end
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_por_span: assert property ($rose(ready) && !seen_q |-> up_q >= POR_CYCLES && up_q <= POR_CYCLES + 8)
      else $error("ready after wrong start-up span");
   a_por_zero: assert property (!ready && !output_oe_n |-> dac_code == '0)
      else $error("code not zero while held");
   a_pdown_hiz: assert property (ready ##1 (!reset_powerdown_pin) [*6] |-> output_oe_n && switch_ctrl == 3'h0)
      else $error("output not released in power-down");
   a_pdown_ready: assert property (output_oe_n [*2] |-> !ready)
      else $error("ready during power-down");
   a_leave_hold: assert property ($rose(reset_powerdown_pin) |-> !ready [*2] ##[1:6] ready)
      else $error("wrong hold after power-down");
   a_sw_gate: assert property (ready && !output_oe_n && mode_q != MODE_DATA && !$past(wr_en) |->
      switch_ctrl == ($past(switch_or_bitstream_in) ? sw_q : 3'h0))
      else $error("switch gate wrong");
   a_pulse_sel: assert property (ready && !output_oe_n && mode_q == MODE_PULSE && !$past(wr_en) && !$past(wr_en, 2)
      && sync_in == $past(sync_in) && sync_in == $past(sync_in, 2) && sync_in == $past(sync_in, 3)
      |-> dac_code == (sync_in ? hi_q : lo_q))
      else $error("pulse level wrong");
   a_data_zero: assert property (ready && mode_q == MODE_DATA && $rose(sync_in) |-> ##[2:4] dac_code == '0)
      else $error("data sync did not zero code");
   a_settle_span: assert property ($fell(unsettled) && !output_oe_n |-> on_q >= 10'h18f && on_q <= 10'h191)
      else $error("settling span wrong");
   a_sine_zero: assert property (ready && mode_q == MODE_SINE && $rose(sync_in) |-> ##[2:4] dac_code == '0)
      else $error("sine sync did not zero code");
   c_settle: cover property ($fell(unsettled));
   c_pulse: cover property (mode_q == MODE_PULSE && $rose(sync_in));
   c_pdown: cover property ($fell(output_oe_n));
   c_ready: cover property ($rose(ready));
endmodule
bind dac_ctrl dac_ctrl_monitor #(.POR_CYCLES(POR_CYCLES)) mon (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
   .switch_or_bitstream_in(switch_or_bitstream_in), .sync_in(sync_in), .reset_powerdown_pin(reset_powerdown_pin),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .dac_code(dac_code),
   .output_oe_n(output_oe_n), .switch_ctrl(switch_ctrl), .ready(ready), .unsettled(unsettled));

/* bench/host_pins.sv */
`timescale 1ns/100ps
module host_pins (
   input wire logic clk_sys,
   input wire logic [1:0] density,
   input wire logic gate_level,
   input wire logic sync_req,
   output logic switch_or_bitstream_in,
   output logic sync_in
);
   logic [5:0] ph_q = 6'h00;
   logic [1:0] low_q = 2'h0;
   initial switch_or_bitstream_in = 1'b0;
   initial sync_in = 1'b0;
   // One bit per sixteen clocks
   always @(posedge clk_sys) begin
      ph_q <= ph_q + 6'h01;
      case (density)
         2'h0: switch_or_bitstream_in <= ph_q[5:4] == 2'h0;
         2'h1: switch_or_bitstream_in <= ph_q[4];
         2'h2: switch_or_bitstream_in <= ph_q[5:4] != 2'h0;
         default: switch_or_bitstream_in <= gate_level;
      endcase
      low_q <= sync_in ? 2'h0 : (low_q == 2'h3 ? low_q : low_q + 2'h1);
      if (!sync_req) sync_in <= 1'b0;
      else if (low_q >= 2'h2) sync_in <= 1'b1;
   end
endmodule

/* bench/dac_ctrl_tb.sv */
`timescale 1ns/100ps
module dac_ctrl_tb;
   import dac_ctrl_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic pin = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic gate = 1'b0;
   logic sreq = 1'b0;
   logic ce = 1'b1;
   logic [1:0] dens = 2'h3;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wr_data = '0;
   logic [DATA_W-1:0] rd_data;
   logic signed [CODE_W-1:0] dac_code;
   logic bs, sync, oe_n, ready, unsettled;
   logic [2:0] sw;
   logic [15:0] v;
   int n_errors = 0;
   int tests_run = 0;
   always #25 clk_sys = ~clk_sys;
   host_pins host (.clk_sys(clk_sys), .density(dens), .gate_level(gate), .sync_req(sreq),
      .switch_or_bitstream_in(bs), .sync_in(sync));
   dac_ctrl #(.POR_CYCLES(16)) dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .switch_or_bitstream_in(bs),
      .sync_in(sync), .reset_powerdown_pin(pin), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .dac_code(dac_code), .output_oe_n(oe_n), .switch_ctrl(sw), .ready(ready),
      .unsettled(unsettled));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 100 && ready !== 1'b1; i++) tick(1);
      chk(ready, 1'b1);
   endtask
   function automatic logic [15:0] code_of(input int n, input int g);
      logic signed [15:0] e;
      e = 16'((n - 8) * int'(FS_STEP));
      return e >>> (g > 6 ? 6 : g);
   endfunction
   task automatic t_por();
      logic [3:0] ra [6] = '{ADDR_MODE, ADDR_GAIN, ADDR_SWITCH, ADDR_SINE_FREQ, ADDR_SINE_AMP, 4'hf};
      logic [15:0] re [6] = '{16'h0000, 16'h0000, 16'h0000, SINE_FREQ_RST, 16'(SINE_AMP_RST), 16'h0000};
      wr(ADDR_MODE, 16'h0002);
      tick(1);
      chk(ready, 1'b0);
      chk(dac_code, 16'h0000);
      wait_ready();
      for (int i = 0; i < 6; i++) begin
         rd(ra[i], v);
         chk(v, re[i]);
      end
   endtask
   task automatic t_data();
      wr(ADDR_MODE, 16'h0002);
      dens <= 2'h2;
      tick(400);
      for (int g = 0; g < 8; g++) begin
         wr(ADDR_GAIN, 16'(g));
         tick(40);
         chk(dac_code, code_of(12, g));
      end
      wr(ADDR_GAIN, 16'h0000);
      dens <= 2'h0;
      tick(400);
      chk(dac_code, code_of(4, 0));
      @(posedge clk_sys);
      dens <= 2'h1;
      tick(400);
      chk(dac_code, 16'h0000);
   endtask
   task automatic t_sync();
      int first;
      logic [15:0] last;
      first = -1;
      last = 16'h0000;
      @(posedge clk_sys);
      dens <= 2'h3;
      gate <= 1'b1;
      sreq <= 1'b1;
      for (int i = 0; i < 200; i++) begin
         tick(1);
         if (i == 5) chk(dac_code, 16'h0000);
         if (i == 5) chk(unsettled, 1'b1);
         if (i > 3 && dac_code !== last) begin
            if (first < 0) first = i;
            chk(16'((i - first) % 16), 16'h0000);
            last = dac_code;
         end
      end
      chk(16'(((first + 2) % 16) / 3), 16'h0000);
      chk(dac_code, code_of(12, 0));
      rd(ADDR_STATUS, v);
      chk(v, 16'((int'(MODE_DATA) << STAT_MODE_LSB) | (1 << STAT_SYNC_BIT) | (1 << STAT_UNSETTLED_BIT)
         | (1 << STAT_READY_BIT)));
      chk(unsettled, 1'b1);
      tick(220);
      chk(unsettled, 1'b0);
      @(posedge clk_sys);
      sreq <= 1'b0;
   endtask
   task automatic t_pulse();
      wr(ADDR_PULSE_LOW, 16'h8000);
      wr(ADDR_PULSE_HIGH, 16'h7fff);
      wr(ADDR_MODE, 16'h0003);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_sys);
         sreq <= k[0];
         tick(6);
         chk(dac_code, k[0] ? 16'h7fff : 16'h8000);
      end
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(ADDR_PULSE_LOW, 16'h1234);
      ce <= 1'b1;
      tick(4);
      chk(dac_code, 16'h8000);
      wr(ADDR_SWITCH, 16'h0005);
      wr(ADDR_DC_LEVEL, 16'hc000);
      wr(ADDR_MODE, 16'h0001);
      tick(4);
      chk(dac_code, 16'hc000);
      chk(sw, 3'h5);
   endtask
   task automatic t_switch();
      wr(ADDR_MODE, 16'h0000);
      for (int s = 0; s < 16; s++) begin
         wr(ADDR_SWITCH, 16'(s >> 1));
         gate <= s[0];
         tick(4);
         chk(sw, s[0] ? 3'(s >> 1) : 3'h0);
      end
      wr(ADDR_SINE_AMP, 16'h00ff);
      wr(ADDR_SINE_FREQ, 16'hffff);
      tick(200);
      chk(16'(dac_code == 16'sh0000), 16'h0000);
      @(posedge clk_sys);
      sreq <= 1'b1;
      tick(5);
      chk(dac_code, 16'h0000);
   endtask
   task automatic t_pdown();
      wr(ADDR_SWITCH, 16'h0005);
      @(posedge clk_sys);
      pin <= 1'b0;
      sreq <= 1'b0;
      tick(12);
      chk({oe_n, ready, sw}, 5'h10);
      @(posedge clk_sys);
      pin <= 1'b1;
      tick(3);
      chk(ready, 1'b0);
      wait_ready();
      rd(ADDR_SWITCH, v);
      chk(v, 16'h0000);
   endtask
   task automatic summarize();
      $display("errors %0d, checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      t_por();
      t_data();
      t_sync();
      t_pulse();
      t_switch();
      t_pdown();
      summarize();
   end
   initial begin
      #500000;
      n_errors++;
      summarize();
   end
endmodule
